//--- hw/csb_pkg.sv
// Constants for the clocked serial addressed bus port
//
// Summary of operation
// - Release trigger write forces output latch high
// - Release trigger self-clears; held zero when disabled
// - Command trigger clears latch low, self-clears
// - Control register resets zero, byte-writable
// - Address match flag zero while channel disabled
// - Transfers move eight bits, one per clock
// - Shift on falling edge, latch drives output
// - Sample serial input on rising edge
// - Stop after eight bits, set interrupt flag
// - Mode bit 2 selects MSB or LSB first
// - Order reverses written bits; shift fixed
// - Write starts transfer if enabled and idle
// - Enable after write does not start transfer
// - Bus mode data pin is open-drain
// - Data rising with clock high is release
// - Data falling with clock high is command
// - Master makes conditions, slave busy, either ack
// - Master clocks from byte start until busy ends
// - Wakeup raises interrupt only on address match
// - Hardware classifies bytes address, command, data
// - Byte after release and command is compared
// - Clock from pin, timer or prescaler
package csb_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [15:0] IDX_MODE  = 16'hFF60;
  localparam logic [15:0] IDX_CTRL  = 16'hFF61;
  localparam logic [15:0] IDX_SHIFT = 16'hFF62;
  localparam logic [15:0] IDX_SADDR = 16'hFF63;
  localparam logic [15:0] IDX_STAT  = 16'hFF64;
  localparam logic [17:0] ADDR_MODE  = {IDX_MODE, 2'b00};
  localparam logic [17:0] ADDR_CTRL  = {IDX_CTRL, 2'b00};
  localparam logic [17:0] ADDR_SHIFT = {IDX_SHIFT, 2'b00};
  localparam logic [17:0] ADDR_SADDR = {IDX_SADDR, 2'b00};
  localparam logic [17:0] ADDR_STAT  = {IDX_STAT, 2'b00};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int MODE_EN    = 7;
  localparam int MODE_MATCH = 6;
  localparam int MODE_WUP   = 5;
  localparam int MODE_SEL1  = 4;
  localparam int MODE_SEL0  = 3;
  localparam int MODE_ORDER = 2;
  localparam int MODE_CK1   = 1;
  localparam int MODE_CK0   = 0;
  localparam int CTRL_REL   = 0;
  localparam int CTRL_CMD   = 1;
  localparam int CTRL_RELD  = 2;
  localparam int CTRL_CMDD  = 3;
  localparam int STAT_IRQ   = 0;
  localparam int STAT_BUSY  = 1;
  localparam int STAT_KIND  = 2;

  // ************************************************************
  // Reset values, codes and timing
  // ************************************************************
  localparam logic [7:0] MODE_RST  = 8'h00;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] SADDR_RST = 8'h00;
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_CMD  = 2'h1;
  localparam logic [1:0] KIND_ADDR = 2'h2;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;
  localparam logic [3:0] BITS      = 4'h8;
  localparam logic [3:0] PRESC_DIV = 4'h4;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } csb_state_type;

endpackage

//--- hw/csb_top.sv
// Serial channel with 3-wire and addressed bus signalling
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module csb_top
  import csb_pkg::*;
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  // AXI4-Lite write address
  input  wire logic [17:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // AXI4-Lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // AXI4-Lite read address
  input  wire logic [17:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  // AXI4-Lite read data
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // Internal clock sources
  input  wire logic        i_timer_tick,
  // Serial pins
  input  wire logic        i_serial_clock_pin,
  output logic             o_serial_clock_pin,
  output logic             o_serial_clock_pin_oe,
  input  wire logic        i_serial_in_pin,
  output logic             o_serial_out_pin,
  input  wire logic        i_bus_data_pin_a,
  output logic             o_bus_data_pin_a,
  output logic             o_bus_data_pin_a_oe,
  // Channel interrupt request flag
  output logic             o_channel_irq_flag
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]    mode_q;          // Mode register, match bit unused
  logic          rel_trig_q;      // Pending release trigger
  logic          cmd_trig_q;      // Pending command trigger
  logic          rel_det_q;       // Release condition seen
  logic          cmd_det_q;       // Command condition seen
  logic          match_q;         // Address match result
  logic [7:0]    shift_q;         // Shift register, wire order
  logic [7:0]    saddr_q;         // Own slave address
  logic          irq_q;           // Channel interrupt flag
  logic          latch_q;         // Serial data output latch
  logic [1:0]    kind_q;          // Class of current byte
  logic [3:0]    cnt_q;           // Falling edges this byte
  logic [3:0]    presc_q;         // Prescaler counter
  logic          sck_q;           // Internally made clock level
  logic          sck_oe_q;        // Clock pin drive enable
  logic          bus_oe_q;        // Open-drain pull-low enable
  logic          bus_out_q;       // Open-drain output level
  csb_state_type st_q;            // Transfer state

  // ************************************************************
  // Bus slave state
  // ************************************************************
  logic          awready_q;
  logic          wready_q;
  logic          aw_v_q;          // Write address held
  logic          w_v_q;           // Write data held
  logic [17:0]   aw_a_q;
  logic [7:0]    w_d_q;           // Only the low lane is kept
  logic          w_s_q;           // Low lane strobe
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          arready_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0]    sync1_q;         // First stage, read by stage two
  logic [2:0]    sync2_q;         // Stable pin levels
  logic [2:0]    sync3_q;         // Previous stable levels

  // Three flops per pin, two to synchronise and one for edges: clock, serial in, bus data
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      sync3_q <= 3'h7;
    end else begin
      sync1_q <= {i_bus_data_pin_a, i_serial_in_pin,
                  i_serial_clock_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ************************************************************
  // Decoding
  // ************************************************************
  wire en        = mode_q[MODE_EN];
  wire wakeup_control       = mode_q[MODE_WUP];
  wire lsb_first = mode_q[MODE_ORDER];
  wire bus_mode  = mode_q[MODE_SEL1] & ~mode_q[MODE_SEL0];
  wire ext_clk   = ~mode_q[MODE_CK1];
  wire sck_s     = sync2_q[0];
  wire data_s    = bus_mode ? sync2_q[2] : sync2_q[1];
  wire busy      = (st_q == ST_SHIFT);

  wire wr_fire   = aw_v_q & w_v_q & ~bvalid_q;
  wire wr_ok     = wr_fire & w_s_q;
  wire wr_mode   = wr_ok & (aw_a_q == ADDR_MODE);
  wire wr_ctrl   = wr_ok & (aw_a_q == ADDR_CTRL);
  wire wr_shift  = wr_ok & (aw_a_q == ADDR_SHIFT);
  wire wr_saddr  = wr_ok & (aw_a_q == ADDR_SADDR);
  wire wr_stat   = wr_ok & (aw_a_q == ADDR_STAT);
  wire wr_hit    = (aw_a_q == ADDR_MODE) | (aw_a_q == ADDR_CTRL) |
                   (aw_a_q == ADDR_SHIFT) | (aw_a_q == ADDR_SADDR) |
                   (aw_a_q == ADDR_STAT);
  wire rd_fire   = i_arvalid & arready_q;

  // Order select mirrors the bus-side view of the shift register
  wire [7:0] wd_rev;
  wire [7:0] sh_rev;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign wd_rev[gi] = w_d_q[7 - gi];
      assign sh_rev[gi] = shift_q[7 - gi];
    end
  endgenerate
  wire [7:0] wd_ord = lsb_first ? wd_rev : w_d_q;
  wire [7:0] sh_ord = lsb_first ? sh_rev : shift_q;

  // ************************************************************
  // Clock sources and edges
  // ************************************************************
  // prescaler or timer tick
  wire presc_tick = (presc_q == PRESC_DIV - 4'h1);
  wire int_tick   = mode_q[MODE_CK0] ? presc_tick : i_timer_tick;
  // internal clock runs through the byte
  wire int_fall   = busy & ~ext_clk & int_tick & sck_q;
  wire int_rise   = busy & ~ext_clk & int_tick & ~sck_q;
  wire ext_fall   = busy & ext_clk & sync3_q[0] & ~sck_s;
  wire ext_rise   = busy & ext_clk & ~sync3_q[0] & sck_s;
  wire fall_ev    = (int_fall | ext_fall) & (cnt_q != BITS);
  // sample edge, only after a bit was put out
  wire rise_ev    = (int_rise | ext_rise) & (cnt_q != 4'h0);
  wire done_ev    = rise_ev & (cnt_q == BITS);
  wire [7:0] rx   = {shift_q[6:0], data_s};

  // start only when enabled and the clock is idle
  wire can_start  = en & ~busy & (~ext_clk | sck_s);
  wire start_ev   = wr_shift & can_start;

  // conditions are read from the bus data pin, whichever end drives it
  // conditions need clock high and no bit running
  wire cond_ok    = en & bus_mode & sck_s & (cnt_q == 4'h0);
  wire rel_ev     = cond_ok & ~sync3_q[2] & sync2_q[2];
  wire cmd_ev     = cond_ok & sync3_q[2] & ~sync2_q[2];

  // compare address byte with own address
  wire addr_done  = done_ev & (kind_q == KIND_ADDR);
  wire addr_hit   = (rx == saddr_q);
  // wakeup gates the interrupt to matching addresses
  wire irq_set    = done_ev & (~wakeup_control | (addr_done & addr_hit));

  // ************************************************************
  // Read mux
  // ************************************************************
  wire [7:0] rd_mode = {mode_q[7], match_q, mode_q[5:0]};
  wire [7:0] rd_ctrl = {4'h0, cmd_det_q, rel_det_q, 2'h0};
  wire [7:0] rd_stat = {4'h0, kind_q, busy, irq_q};
  wire       rd_hit  = (i_araddr == ADDR_MODE) |
                       (i_araddr == ADDR_CTRL) |
                       (i_araddr == ADDR_SHIFT) |
                       (i_araddr == ADDR_SADDR) |
                       (i_araddr == ADDR_STAT);
  wire [7:0] rd_byte =
    (i_araddr == ADDR_MODE)  ? rd_mode :
    (i_araddr == ADDR_CTRL)  ? rd_ctrl :
    (i_araddr == ADDR_SHIFT) ? sh_ord  :
    (i_araddr == ADDR_SADDR) ? saddr_q :
    (i_araddr == ADDR_STAT)  ? rd_stat : 8'h00;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  // Address and data are taken in either order, answered together
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_v_q    <= 1'b0;
      w_v_q     <= 1'b0;
      aw_a_q    <= 18'h00000;
      w_d_q     <= 8'h00;
      w_s_q     <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OK;
    end else begin
      // Hold one address until answered
      if (i_awvalid & awready_q) begin
        aw_v_q    <= 1'b1;
        aw_a_q    <= i_awaddr;
        awready_q <= 1'b0;
      end
      // Hold one data word until answered
      if (i_wvalid & wready_q) begin
        w_v_q    <= 1'b1;
        w_d_q    <= i_wdata[7:0];
        w_s_q    <= i_wstrb[0];
        wready_q <= 1'b0;
      end
      // Both present: perform and answer
      if (wr_fire) begin
        aw_v_q   <= 1'b0;
        w_v_q    <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OK : RESP_ERR;
      end
      // Response taken: reopen both channels
      if (bvalid_q & i_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  // One read in flight; data captured at address handshake
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= RESP_OK;
    end else if (rd_fire) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, rd_byte};
      rresp_q   <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rvalid_q & i_rready) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Mode and slave address; the match bit is never stored here
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      mode_q  <= MODE_RST;
      saddr_q <= SADDR_RST;
    end else begin
      if (wr_mode) begin
        mode_q <= {w_d_q[7], 1'b0, w_d_q[5:0]};
      end
      if (wr_saddr) begin
        saddr_q <= w_d_q;
      end
    end
  end

  // ************************************************************
  // Trigger bits and output latch
  // ************************************************************
  // Triggers live one cycle; software should not fire them mid byte
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rel_trig_q <= CTRL_RST[CTRL_REL];
      cmd_trig_q <= CTRL_RST[CTRL_CMD];
      latch_q    <= 1'b1;
    end else begin
      rel_trig_q <= wr_ctrl & en & w_d_q[CTRL_REL];
      cmd_trig_q <= wr_ctrl & en & w_d_q[CTRL_CMD];
      if (rel_trig_q) begin
        latch_q <= 1'b1;
      end else if (cmd_trig_q) begin
        latch_q <= 1'b0;
      end else if (fall_ev) begin
        latch_q <= shift_q[7];
      end
    end
  end

  // ************************************************************
  // Transfer engine
  // ************************************************************
  // eight bits per byte, one per clock cycle
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 4'h0;
      shift_q <= 8'h00;
    end else if (~en) begin
      // Disabled: plain storage, writes never arm a later start
      st_q  <= ST_IDLE;
      cnt_q <= 4'h0;
      // data written while disabled just sits
      if (wr_shift) begin
        shift_q <= wd_ord;
      end
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (wr_shift) begin
            shift_q <= wd_ord;
          end
          if (start_ev) begin
            st_q  <= ST_SHIFT;
            cnt_q <= 4'h0;
          end
        end
        ST_SHIFT: begin
          // count falling edges of the clock
          if (fall_ev) begin
            cnt_q <= cnt_q + 4'h1;
          end
          // take input bit into the low end
          if (rise_ev) begin
            shift_q <= rx;
          end
          if (done_ev) begin
            st_q  <= ST_IDLE;
            cnt_q <= 4'h0;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Internal serial clock
  // ************************************************************
  // Idles high so a slave sees no stray edge between bytes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      presc_q  <= 4'h0;
      sck_q    <= 1'b1;
      sck_oe_q <= 1'b0;
    end else begin
      presc_q  <= presc_tick ? 4'h0 : presc_q + 4'h1;
      sck_oe_q <= en & ~ext_clk;
      if (int_fall | int_rise) begin
        sck_q <= ~sck_q;
      end else if (~busy) begin
        sck_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Bus conditions and byte class
  // ************************************************************
  // Detection is placed after the clears so a new event wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rel_det_q <= 1'b0;
      cmd_det_q <= 1'b0;
      kind_q    <= KIND_DATA;
      match_q   <= 1'b0;
    end else if (~en) begin
      // match flag reads zero while disabled
      rel_det_q <= 1'b0;
      cmd_det_q <= 1'b0;
      kind_q    <= KIND_DATA;
      match_q   <= 1'b0;
    end else begin
      if (start_ev) begin
        kind_q    <= (rel_det_q & cmd_det_q) ? KIND_ADDR :
                     cmd_det_q ? KIND_CMD : KIND_DATA;
        cmd_det_q <= 1'b0;
        if (~cmd_det_q) begin
          rel_det_q <= 1'b0;
        end
      end
      // address result, a miss drops the release state
      if (addr_done) begin
        match_q <= addr_hit;
        if (~addr_hit) begin
          rel_det_q <= 1'b0;
        end
      end
      if (rel_ev) begin
        rel_det_q <= 1'b1;
        cmd_det_q <= 1'b0;
      end
      if (cmd_ev) begin
        cmd_det_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Interrupt flag and pin drive
  // ************************************************************
  // Flag is write-one-to-clear; a completion in that cycle wins
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      irq_q     <= 1'b0;
      bus_oe_q  <= 1'b0;
      bus_out_q <= 1'b0;
    end else begin
      // flag set on completion; with wakeup on, only on an address match
      if (irq_set) begin
        irq_q <= 1'b1;
      end else if (wr_stat & w_d_q[STAT_IRQ]) begin
        irq_q <= 1'b0;
      end
      // open-drain: only ever pull the line low
      bus_oe_q  <= en & bus_mode & ~latch_q;
      bus_out_q <= 1'b0;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_awready             = awready_q;
  assign o_wready              = wready_q;
  assign o_bvalid              = bvalid_q;
  assign o_bresp               = bresp_q;
  assign o_arready             = arready_q;
  assign o_rvalid              = rvalid_q;
  assign o_rdata               = rdata_q;
  assign o_rresp               = rresp_q;
  assign o_serial_clock_pin    = sck_q;
  assign o_serial_clock_pin_oe = sck_oe_q;
  assign o_serial_out_pin      = latch_q;
  assign o_bus_data_pin_a      = bus_out_q;
  assign o_bus_data_pin_a_oe   = bus_oe_q;
  assign o_channel_irq_flag    = irq_q;

endmodule

//--- testbench/csb_top_asserts.sv
// Checker of pin and bus timing relations of the serial port
`timescale 1ns/10ps
module csb_top_asserts(
  input wire logic        i_core_clk, i_rst, i_awvalid, o_awready,
  input wire logic        i_wvalid, o_wready, o_bvalid, i_arvalid,
  input wire logic        o_arready, o_rvalid,
  input wire logic [31:0] o_rdata,
  input wire logic        o_serial_clock_pin, o_serial_clock_pin_oe,
  input wire logic        o_serial_out_pin, o_bus_data_pin_a,
  input wire logic        o_bus_data_pin_a_oe, o_channel_irq_flag
);
  logic [3:0] falls_q;  // Clock falls since the flag last rose
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Only internally made clocks are counted
  always_ff @(posedge i_core_clk) begin
    if (i_rst || $rose(o_channel_irq_flag)) falls_q <= 4'h0;
    else if (o_serial_clock_pin_oe && $fell(o_serial_clock_pin))
      falls_q <= falls_q + 4'h1;
  end
  AST_EIGHT_FALLS: assert property (
    $rose(o_channel_irq_flag) && o_serial_clock_pin_oe |-> falls_q == 4'h8)
    else $error("flag rose without eight clock falls");
  AST_STOP_HIGH: assert property (
    $rose(o_channel_irq_flag) && o_serial_clock_pin_oe
    |-> o_serial_clock_pin [*6])
    else $error("clock kept running after the byte");
  AST_OD_ZERO: assert property (
    o_bus_data_pin_a == 1'b0)
    else $error("bus data pin drives high");
  AST_OD_LAG: assert property (
    o_bus_data_pin_a_oe |-> !$past(o_serial_out_pin))
    else $error("bus pulled low while latch high");
  AST_IRQ_HOLD: assert property (
    $fell(o_channel_irq_flag) |-> o_bvalid)
    else $error("flag dropped without a write");
  AST_B_LAT: assert property (
    i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
    else $error("write response late");
  AST_R_LAT: assert property (
    i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  AST_R_UPPER: assert property (
    o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Main scenarios seen
  cover property ($rose(o_channel_irq_flag) && o_serial_clock_pin_oe);
  cover property ($rose(o_channel_irq_flag) && !o_serial_clock_pin_oe);
  cover property ($rose(o_bus_data_pin_a_oe));
endmodule
bind csb_top csb_top_asserts u_chk(.*);

//--- testbench/csb_peer.sv
// Serial peripheral model facing the 3-wire port
`timescale 1ns/10ps
module csb_peer(
  input wire logic       i_clk, i_load, i_sck, i_dout,
  input wire logic [7:0] i_val,
  output logic           o_din,
  output logic [7:0]     o_rx
);
  logic [7:0] sr_q = 8'h00;  // Outgoing bits leave at the top
  logic       sck_q = 1'b1;  // Clock level one cycle ago
  always_ff @(posedge i_clk) begin
    sck_q <= i_sck;
    if (i_load) sr_q <= i_val;
    else if (i_sck && !sck_q) sr_q <= {sr_q[6:0], i_dout};
  end
  assign o_din = sr_q[7];  // Next bit offered right after the rise
  assign o_rx  = sr_q;
endmodule

//--- testbench/tb_top.sv
// Self-checking bench of the serial addressed bus port
`timescale 1ns/10ps
module tb_top;
  import csb_pkg::*;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0;
  logic arv = 1'b0, rre = 1'b0, xsck = 1'b1, sda = 1'b1, pld = 1'b0;
  logic [17:0] awa = 18'h0, ara = 18'h0;
  logic [31:0] wd = 32'h0;
  logic [7:0]  pv = 8'h0, d, p;
  logic [7:0]  md [4] = '{8'h83, 8'h87, 8'h82, 8'h86};
  logic [2:0]  tc = 3'h0;      // Timer source divider
  logic [33:0] eq[$];          // Expected {resp, data} per read
  string       nq[$];
  int          n_fail = 0, check_count = 0;
  wire awr, wrd, bv, arr, rv, sck, soe, sout, bd, boe, irq, din;
  wire [1:0]  br, rr;
  wire [31:0] rdt;
  wire [7:0]  prx;
  wire tick  = tc == 3'h0;
  wire sline = soe ? sck : xsck;    // Pulled up when nobody drives
  wire bline = sda & ~(boe & ~bd);  // Open-drain with pull-up
  always #12.5 clk = ~clk;
  always @(posedge clk) tc <= tc + 3'h1;
  csb_top u_dut(.i_core_clk(clk), .i_rst(rst), .i_awaddr(awa),
    .i_awvalid(awv), .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF),
    .i_wvalid(wv), .o_wready(wrd), .o_bresp(br), .o_bvalid(bv),
    .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdt), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
    .i_timer_tick(tick), .i_serial_clock_pin(sline),
    .o_serial_clock_pin(sck), .o_serial_clock_pin_oe(soe),
    .i_serial_in_pin(din), .o_serial_out_pin(sout),
    .i_bus_data_pin_a(bline), .o_bus_data_pin_a(bd),
    .o_bus_data_pin_a_oe(boe), .o_channel_irq_flag(irq));
  csb_peer u_peer(.i_clk(clk), .i_load(pld), .i_sck(sline),
    .i_dout(sout), .i_val(pv), .o_din(din), .o_rx(prx));
  task automatic print_verdict();
    if (n_fail == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(string nm, logic [33:0] s, logic [33:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  // A bound that ran out ends the run
  task automatic lim(int t);
    if (t >= 2000) begin
      n_fail++;
      print_verdict();
    end
  endtask
  // Read results are compared as they appear
  always @(posedge clk)
    if (rv && rre) chk(nq.pop_front(), {rr, rdt}, eq.pop_front());
  task automatic wr(logic [17:0] a, logic [7:0] v);
    int t;
    awa <= a; wd <= {24'h0, v}; awv <= 1'b1; wv <= 1'b1; bre <= 1'b1;
    t = 0;
    do begin
      @(posedge clk); t++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wrd) wv <= 1'b0;
    end while (!bv && t < 2000);
    chk("bresp", br, RESP_OK);
    lim(t);
  endtask
  task automatic rd(logic [17:0] a, logic [33:0] e, string nm);
    int t;
    eq.push_back(e); nq.push_back(nm);
    ara <= a; arv <= 1'b1; rre <= 1'b1;
    t = 0;
    do begin
      @(posedge clk); t++;
      if (arv && arr) arv <= 1'b0;
    end while (!rv && t < 2000);
    lim(t);
  endtask
  task automatic wirq();
    int t;
    for (t = 0; t < 2000 && irq !== 1'b1; t++) @(posedge clk);
    lim(t);
  endtask
  function automatic logic [7:0] rv8(logic [7:0] x);
    for (int i = 0; i < 8; i++) rv8[i] = x[7 - i];
  endfunction
  // Bus master: command, release, command, then one address byte
  task automatic bbyte(logic [7:0] a);
    sda <= 1'b0; repeat (8) @(posedge clk);
    sda <= 1'b1; repeat (8) @(posedge clk);
    sda <= 1'b0; repeat (8) @(posedge clk);
    rd(ADDR_CTRL, 34'h0C, "ctrl_seen");
    wr(ADDR_SHIFT, 8'hFF);
    for (int i = 7; i >= 0; i--) begin
      xsck <= 1'b0; repeat (4) @(posedge clk);
      sda <= a[i]; repeat (4) @(posedge clk);
      xsck <= 1'b1; repeat (8) @(posedge clk);
    end
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    void'($urandom(26));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ADDR_CTRL, 34'h0, "ctrl_rst");
    rd(ADDR_MODE, 34'h0, "mode_rst");
    rd(18'h0, {RESP_ERR, 32'h0}, "unmapped");
    // triggers only while enabled
    // Trigger bits drive the output latch
    wr(ADDR_MODE, 8'h83);
    wr(ADDR_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    chk("latch_low", sout, 1'b0);
    rd(ADDR_CTRL, 34'h0, "ctrl_selfclr");
    wr(ADDR_CTRL, 8'h01);
    repeat (4) @(posedge clk);
    chk("latch_high", sout, 1'b1);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    chk("latch_held", sout, 1'b1);
    // Data written before enabling must stay put
    wr(ADDR_SHIFT, 8'hA5);
    wr(ADDR_MODE, 8'h83);
    repeat (40) @(posedge clk);
    chk("no_start", irq, 1'b0);
    rd(ADDR_STAT, 34'h0, "stat_idle");
    // Both bit orders, prescaler and timer clocks
    for (int m = 0; m < 4; m++) begin
      d = 8'($urandom);
      p = 8'($urandom);
      pv <= p; pld <= 1'b1;
      @(posedge clk);
      pld <= 1'b0;
      wr(ADDR_MODE, md[m]);
      wr(ADDR_SHIFT, d);
      wirq();
      repeat (2) @(posedge clk);
      chk("peer_rx", prx, md[m][2] ? rv8(d) : d);
      rd(ADDR_SHIFT, {26'h0, md[m][2] ? rv8(p) : p}, "shift_rx");
      rd(ADDR_STAT, 34'h1, "stat_done");
      wr(ADDR_STAT, 8'h01);
      chk("irq_clr", irq, 1'b0);
    end
    // Addressed bus with wakeup on an external clock
    wr(ADDR_SADDR, 8'h5A);
    wr(ADDR_MODE, 8'hB0);
    wr(ADDR_CTRL, 8'h02);
    repeat (4) @(posedge clk);
    chk("bus_pull", bline, 1'b0);
    wr(ADDR_CTRL, 8'h01);
    bbyte(8'h33);
    rd(ADDR_MODE, 34'hB0, "mode_miss");
    chk("irq_miss", irq, 1'b0);
    bbyte(8'h5A);
    rd(ADDR_MODE, 34'hF0, "mode_match");
    rd(ADDR_STAT, 34'h9, "stat_addr");
    wr(ADDR_MODE, 8'h30);
    rd(ADDR_MODE, 34'h30, "match_off");
    print_verdict();
  end
endmodule
